/* core/irc_core.sv */
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module irc_core
    import irc_pkg::*;
#(
    parameter logic        LEVEL_TRIG  = 1'b1,
    parameter logic        STOP_ENABLE = 1'b1,
    parameter irc_period_e PERIOD_SEL  = IRC_PER_FULL,
    parameter int          STARTUP     = STARTUP_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        irq_n_i,
    input  wire logic        osc32_i,
    input  wire logic        por_i,
    input  wire logic        reset_pin_i,
    output var  logic        reset_pin_o,
    output var  logic        reset_pin_oe_o,
    input  wire logic        watchdog_timeout_i,
    input  wire logic        illegal_addr_i,
    input  wire logic        mask_bit_i,
    input  wire logic        instr_done_i,
    input  wire logic        swi_fetch_i,
    input  wire logic        stop_exec_i,
    input  wire logic        wait_exec_i,
    input  wire logic        timer_ovf_flag_i,
    input  wire logic        timer_ovf_en_i,
    input  wire logic        timer_rt_flag_i,
    input  wire logic        timer_rt_en_i,
    input  wire logic        serial_flag_i,
    input  wire logic        serial_en_i,
    input  wire logic        twowire_flag_i,
    input  wire logic        twowire_en_i,
    output var  logic        int_take_o,
    output var  logic [15:0] vector_o,
    output var  logic        set_mask_o,
    output var  logic        cpu_clk_run_o,
    output var  logic        osc_run_o,
    output var  logic        timer_clear_o,
    output var  logic        int_reset_o,
    output var  logic        mode_sample_o
);
    typedef struct packed {
        irc_pwr_e         pwr;
        logic             ext_latch;
        logic             irq_d;
        logic             osc_d;
        logic             por_d;
        logic             ext_rst_d;
        logic             wdog_d;
        logic             any_rst_d;
        logic [14:0]      pic_cnt;
        logic             pic_flag;
        logic             pic_en;
        logic             swi_pend;
        logic [SRC_N-1:0] swi_snap;
        logic [15:0]      vector;
        logic             take;
        logic             mask_set;
        logic             timer_clr;
        logic             rst;
        logic [2:0]       pull_cnt;
        logic             pull_drive;
        logic [1:0]       echo_cnt;
        logic             stopdis;
        logic             mode_pulse;
        logic             ack;
        logic [7:0]       rdata;
    } irc_state_s;

    irc_state_s r_reg;
    irc_state_s r_next;

    logic [3:0]       pin_q;
    logic             irq_lvl;
    logic             osc_lvl;
    logic             por_lvl;
    logic             rst_pin_lvl;
    logic [14:0]      per_mask;
    logic             ext_req;
    logic             ext_rst;
    logic             por_active;
    logic             int_src;
    logic             int_rst;
    logic [SRC_N-1:0] pend;
    logic [SRC_N-1:0] elig;
    logic [5:0]       idx;

    irc_delay_if por_if ();
    irc_delay_if stp_if ();

    generate
        if (PERIOD_SEL != IRC_PER_QUARTER && PERIOD_SEL != IRC_PER_HALF
            && PERIOD_SEL != IRC_PER_FULL) begin : g_chk
            $error("irc_core: illegal PERIOD_SEL");
        end
    endgenerate

    irc_sync #(
        .W       (4),
        .RST_VAL (4'hB)
    ) u_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .d_i       ({irq_n_i, osc32_i, por_i, reset_pin_i}),
        .q_o       (pin_q)
    );

    irc_delay #(
        .CYCLES (STARTUP)
    ) u_por_dly (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .dly       (por_if.timer)
    );

    irc_delay #(
        .CYCLES (STARTUP)
    ) u_stop_dly (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .dly       (stp_if.timer)
    );

    assign irq_lvl     = pin_q[3];
    assign osc_lvl     = pin_q[2];
    assign por_lvl     = pin_q[1];
    assign rst_pin_lvl = pin_q[0];

    assign per_mask = (PERIOD_SEL == IRC_PER_QUARTER) ? PER_MASK_Q :
                      (PERIOD_SEL == IRC_PER_HALF)    ? PER_MASK_H :
                                                        PER_MASK_F;

    assign ext_req = r_reg.ext_latch | (LEVEL_TRIG & ~irq_lvl);

    assign pend[SRC_EXT]   = ext_req;
    assign pend[SRC_TIMER] = (timer_ovf_flag_i & timer_ovf_en_i)
                           | (timer_rt_flag_i & timer_rt_en_i);
    assign pend[SRC_PER]   = r_reg.pic_flag & r_reg.pic_en;
    assign pend[SRC_SER]   = serial_flag_i & serial_en_i;
    assign pend[SRC_TWO]   = twowire_flag_i & twowire_en_i;

    assign ext_rst    = ~rst_pin_lvl & ~r_reg.pull_drive
                      & (r_reg.echo_cnt == 2'h0);
    assign por_active = por_lvl | por_if.start | por_if.busy;
    assign int_src    = por_active | watchdog_timeout_i | illegal_addr_i
                      | r_reg.stopdis;
    assign int_rst    = ext_rst | int_src;

    assign por_if.start = r_reg.por_d & ~por_lvl;
    assign stp_if.start = (r_reg.pwr == IRC_STOP) & (ext_req | ext_rst);
    assign idx          = wb_adr_i[7:2];

    always_comb begin
        r_next = r_reg;
        r_next.take       = 1'b0;
        r_next.mask_set   = 1'b0;
        r_next.timer_clr  = 1'b0;
        r_next.stopdis    = 1'b0;
        r_next.mode_pulse = 1'b0;
        r_next.ack        = 1'b0;
        r_next.irq_d      = irq_lvl;
        r_next.osc_d      = osc_lvl;
        r_next.por_d      = por_lvl;
        r_next.ext_rst_d  = ext_rst;
        r_next.wdog_d     = watchdog_timeout_i;
        r_next.any_rst_d  = int_rst;
        r_next.rst        = int_rst;
        elig = '0;

        // masked and evaluated at instruction end
        if (!mask_bit_i) begin
            elig = pend;
        end
        // trap waits only for requests pending at its fetch
        if (r_reg.swi_pend) begin
            elig = elig & r_reg.swi_snap;
        end

        if (instr_done_i && r_reg.pwr == IRC_RUN && !int_rst) begin
            if (elig[SRC_EXT]) begin
                r_next.take   = 1'b1;
                r_next.vector = VEC_EXT;
                r_next.ext_latch = 1'b0;
            end else if (elig[SRC_TIMER]) begin
                r_next.take   = 1'b1;
                r_next.vector = VEC_TIMER;
            end else if (elig[SRC_PER]) begin
                r_next.take   = 1'b1;
                r_next.vector = VEC_PERIODIC;
            end else if (elig[SRC_SER]) begin
                r_next.take   = 1'b1;
                r_next.vector = VEC_SERIAL;
            end else if (elig[SRC_TWO]) begin
                r_next.take   = 1'b1;
                r_next.vector = VEC_TWOWIRE;
            end else if (r_reg.swi_pend) begin
                r_next.take     = 1'b1;
                r_next.vector   = VEC_SWI;
                r_next.swi_pend = 1'b0;
            end
            r_next.mask_set = r_next.take;
        end

        if (swi_fetch_i && !int_rst) begin
            r_next.swi_pend = 1'b1;
            r_next.swi_snap = mask_bit_i ? '0 : pend;
        end

        // falling edge captured, set wins over service clear; reset clear wins over set
        if (r_reg.irq_d && !irq_lvl) begin
            r_next.ext_latch = 1'b1;
        end

        if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
            r_next.ack   = 1'b1;
            r_next.rdata = 8'h00;
            if (idx == PIC_CS_IDX) begin
                r_next.rdata[PIC_FLAG_BIT] = r_reg.pic_flag;
                r_next.rdata[PIC_EN_BIT]   = r_reg.pic_en;
            end else if (idx == STATUS_IDX) begin
                r_next.rdata = {r_reg.pwr, r_reg.swi_pend, pend};
            end
        end
        // write zero clears flag, lands on the ack edge
        if (wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack && wb_sel_i[0]
            && idx == PIC_CS_IDX) begin
            if (!wb_dat_i[PIC_FLAG_BIT]) begin
                r_next.pic_flag = 1'b0;
            end
            r_next.pic_en = wb_dat_i[PIC_EN_BIT];
        end

        // counter runs whenever the oscillator runs and no internal reset is active
        if (osc_lvl && !r_reg.osc_d && r_reg.pwr != IRC_STOP) begin
            r_next.pic_cnt = r_reg.pic_cnt + 15'h0001;
            if ((r_reg.pic_cnt & per_mask) == per_mask) begin
                r_next.pic_flag = 1'b1;
            end
        end

        case (r_reg.pwr)
            IRC_RUN: begin
                if (stop_exec_i && !int_rst) begin
                    if (STOP_ENABLE) begin
                        r_next.pwr       = IRC_STOP;
                        r_next.timer_clr = 1'b1;
                    end else begin
                        r_next.stopdis = 1'b1;
                    end
                end else if (wait_exec_i && !int_rst) begin
                    r_next.pwr = IRC_WAIT;
                end
            end
            IRC_WAIT: begin
                if (|pend || int_rst) begin
                    r_next.pwr = IRC_RUN;
                end
            end
            IRC_STOP: begin
                if (stp_if.start) begin
                    r_next.pwr = IRC_START;
                end
            end
            IRC_START: begin
                if (stp_if.done) begin
                    r_next.pwr       = IRC_RUN;
                    r_next.timer_clr = 1'b1;
                end
            end
            default: begin
                r_next.pwr = IRC_RUN;
            end
        endcase

        if (int_rst) begin
            r_next.vector    = VEC_RESET;
            r_next.mask_set  = 1'b1;
            r_next.swi_pend  = 1'b0;
            r_next.ext_latch = 1'b0;
            r_next.pic_cnt   = '0;
            r_next.pic_flag  = 1'b0;
            r_next.pic_en    = 1'b0;
        end

        if (int_rst && !r_reg.any_rst_d) begin
            r_next.pull_cnt = PULL_CYCLES;
        end else if (r_reg.pull_cnt != 3'h0) begin
            r_next.pull_cnt = r_reg.pull_cnt - 3'h1;
        end
        r_next.pull_drive = (r_next.pull_cnt != 3'h0) | int_src;
        if (r_reg.pull_drive) begin
            r_next.echo_cnt = ECHO_CYCLES;
        end else if (r_reg.echo_cnt != 2'h0) begin
            r_next.echo_cnt = r_reg.echo_cnt - 2'h1;
        end

        // mode re-sample on pin or watchdog reset end
        r_next.mode_pulse = (r_reg.ext_rst_d & ~ext_rst)
                          | (r_reg.wdog_d & ~watchdog_timeout_i);
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_reg          <= '0;
            r_reg.pwr      <= IRC_RUN;
            r_reg.irq_d    <= 1'b1;
            r_reg.vector   <= VEC_RESET;
            r_reg.mask_set <= 1'b1;
            r_reg.rst      <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o       = {24'h000000, r_reg.rdata};
    assign wb_ack_o       = r_reg.ack;
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = r_reg.pull_drive;
    assign int_take_o     = r_reg.take;
    assign vector_o       = r_reg.vector;
    assign set_mask_o     = r_reg.mask_set;
    assign cpu_clk_run_o  = (r_reg.pwr == IRC_RUN);
    assign osc_run_o      = (r_reg.pwr != IRC_STOP);
    assign timer_clear_o  = r_reg.timer_clr;
    assign int_reset_o    = r_reg.rst;
    assign mode_sample_o  = r_reg.mode_pulse;
endmodule
`default_nettype wire

/* core/irc_pkg.sv */
// What this block does
// - software trap is always taken, whatever the mask; vector 1FFC/1FFD
// - mask clear: trap served after requests pending at its fetch, before later
// - mask set blocks every maskable request; clearing mask allows them again
// - external pin falling edge latched, synchronised, vectored to 1FFA/1FFB
// - external trigger built as level-and-edge or edge-only
// - external latch clears early in service so one more pulse is kept
// - either timer flag with its enable requests; shared vector 1FF8/1FF9
// - periodic request vectors to 1FF6/1FF7
// - 15-bit counter on 32 kHz input; period 0.25, 0.5 or 1 s at build
// - periodic flag sets on rollover; requests only while enable is set
// - writing zero clears periodic flag, one leaves it; reset clears it
// - enable clear suppresses periodic requests; reset clears enable
// - serial unit flag and enable request through vector 1FF4/1FF5
// - two-wire bus flag and enable request through vector 1FF2/1FF3
// - stop clears timer, halts counter; exit waits 4064 cycles, clears timer
// - periodic counter resumes with the oscillator, not after the delay
// - wait stops CPU clock; enabled timer/periodic/serial/bus request ends it
// - internal reset from pin, power-on, watchdog, illegal address, stop trap
// - internal resets pull pin low max(3-4 cycles, duration); pin only 3-4
// - only end of pin or watchdog reset re-samples operating mode
// - power-on holds reset 4064 cycles, longer while another reset is active
// - on reset mask is set and start vector is 1FFE/1FFF
// - requests wait for instruction end, taken if unmasked and enabled
// - taking an interrupt sets the mask; CPU stacks and restores registers
// - external request is served before a timer request
package irc_pkg;
    localparam logic [15:0] VEC_RESET    = 16'h1FFE;
    localparam logic [15:0] VEC_SWI      = 16'h1FFC;
    localparam logic [15:0] VEC_EXT      = 16'h1FFA;
    localparam logic [15:0] VEC_TIMER    = 16'h1FF8;
    localparam logic [15:0] VEC_PERIODIC = 16'h1FF6;
    localparam logic [15:0] VEC_SERIAL   = 16'h1FF4;
    localparam logic [15:0] VEC_TWOWIRE  = 16'h1FF2;

    localparam logic [5:0]  PIC_CS_IDX   = 6'h12;
    localparam logic [5:0]  STATUS_IDX   = 6'h13;
    localparam int          PIC_FLAG_BIT = 7;
    localparam int          PIC_EN_BIT   = 6;

    localparam int          SRC_N        = 5;
    localparam int          SRC_EXT      = 4;
    localparam int          SRC_TIMER    = 3;
    localparam int          SRC_PER      = 2;
    localparam int          SRC_SER      = 1;
    localparam int          SRC_TWO      = 0;

    localparam logic [14:0] PER_MASK_Q   = 15'h1FFF;
    localparam logic [14:0] PER_MASK_H   = 15'h3FFF;
    localparam logic [14:0] PER_MASK_F   = 15'h7FFF;

    localparam int          STARTUP_CYCLES = 4064;
    localparam logic [2:0]  PULL_CYCLES    = 3'h4;
    localparam logic [1:0]  ECHO_CYCLES    = 2'h3;

    typedef enum logic [1:0] {
        IRC_RUN   = 2'b00,
        IRC_WAIT  = 2'b01,
        IRC_STOP  = 2'b10,
        IRC_START = 2'b11
    } irc_pwr_e;

    typedef enum logic [1:0] {
        IRC_PER_QUARTER = 2'b00,
        IRC_PER_HALF    = 2'b01,
        IRC_PER_FULL    = 2'b10
    } irc_period_e;
endpackage

/* core/irc_delay_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface irc_delay_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

/* core/irc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module irc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= RST_VAL;
            q_o      <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* core/irc_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module irc_delay #(
    parameter int CYCLES = 4064
) (
    input  wire logic  clock_i,
    input  wire logic  reset_n_i,
    irc_delay_if.timer dly
);
    localparam int W = (CYCLES < 2) ? 1 : $clog2(CYCLES);

    typedef struct packed {
        logic         busy;
        logic         done;
        logic [W-1:0] cnt;
    } irc_dly_s;

    irc_dly_s r_reg;
    irc_dly_s r_next;

    generate
        if (CYCLES < 2) begin : g_chk
            $error("irc_delay: CYCLES must be at least 2");
        end
    endgenerate

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (r_reg.busy) begin
            if (r_reg.cnt == '0) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt - W'(1);
            end
        end else if (dly.start) begin
            r_next.busy = 1'b1;
            r_next.cnt  = W'(CYCLES - 1);
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign dly.busy = r_reg.busy;
    assign dly.done = r_reg.done;
endmodule
`default_nettype wire

/* tb/irc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module irc_core_properties
    import irc_pkg::*;
#(
    parameter int STARTUP = 4064
) (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        por_i,
    input wire logic        mask_bit_i,
    input wire logic        instr_done_i,
    input wire logic        stop_exec_i,
    input wire logic        wait_exec_i,
    input wire logic        int_take_o,
    input wire logic [15:0] vector_o,
    input wire logic        set_mask_o,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe_o,
    input wire logic        int_reset_o,
    input wire logic        cpu_clk_run_o,
    input wire logic        osc_run_o,
    input wire logic        timer_clear_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [31:0] gap_reg;
    // cycles since power-on detect dropped
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) gap_reg <= '1;
        else if (por_i) gap_reg <= '0;
        else if (gap_reg != '1) gap_reg <= gap_reg + 32'h1;
    end
    sequence stop_req;
        stop_exec_i && cpu_clk_run_o && !int_reset_o;
    endsequence
    sequence stop_done;
        !osc_run_o ##[0:1] timer_clear_o;
    endsequence
    bus_ack_once_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    take_sets_mask_a: assert property (
        int_take_o |-> set_mask_o) else $error("take without mask set");
    mask_blocks_a: assert property (
        int_take_o && vector_o != VEC_SWI |-> !$past(mask_bit_i))
        else $error("masked request taken");
    take_boundary_a: assert property (
        int_take_o |-> $past(instr_done_i)) else $error("take off boundary");
    pin_pull_a: assert property (
        $rose(reset_pin_oe_o) |-> (reset_pin_oe_o && !reset_pin_o)[*3])
        else $error("pulldown too short");
    por_hold_a: assert property (
        $fell(int_reset_o) |-> gap_reg >= STARTUP)
        else $error("power-on hold too short");
    wait_halt_a: assert property (
        wait_exec_i && cpu_clk_run_o && !int_reset_o |=> !cpu_clk_run_o)
        else $error("cpu clock runs in wait");
    stop_entry_a: assert property (
        stop_req |=> stop_done) else $error("stop entry wrong");
endmodule
`default_nettype wire

/* tb/irc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irc_cpu_model (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic set_mask_i,
    input  wire logic mask_wr_i,
    input  wire logic mask_val_i,
    input  wire logic step_i,
    output var  logic mask_o,
    output var  logic instr_done_o
);
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_o       <= 1'b1;
            instr_done_o <= 1'b0;
        end else begin
            instr_done_o <= step_i;
            if (set_mask_i) mask_o <= 1'b1;
            else if (mask_wr_i) mask_o <= mask_val_i;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_interrupt_and_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_and_reset_control
    import irc_pkg::*;
;
    logic        clock_i, reset_n_i, cyc, stb, we, ack, irq_n, osc, osc_on;
    logic        por, ext_n, wdog, illeg, step, mwr, mval, software_trap_instruction, stp, wt;
    logic        tof, toe, trf, tre, sf, se, twf, twe, mask, idone, take;
    logic        smask, clkrun, oscrun, tclr, irst, msamp, poe, pdat, tk, t;
    logic [7:0]  adr;
    logic [15:0] vec, v;
    logic [31:0] wdat, rdat, r;
    int          err_count, comparisons, ms_cnt, oe_cnt;
    wire logic   pin_w;
    assign pin_w = ext_n & ~poe;
    irc_core #(.PERIOD_SEL(IRC_PER_QUARTER), .STARTUP(8)) dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_n_i(irq_n),
        .osc32_i(osc), .por_i(por), .reset_pin_i(pin_w),
        .reset_pin_o(pdat), .reset_pin_oe_o(poe),
        .watchdog_timeout_i(wdog), .illegal_addr_i(illeg),
        .mask_bit_i(mask), .instr_done_i(idone), .swi_fetch_i(software_trap_instruction),
        .stop_exec_i(stp), .wait_exec_i(wt), .timer_ovf_flag_i(tof),
        .timer_ovf_en_i(toe), .timer_rt_flag_i(trf), .timer_rt_en_i(tre),
        .serial_flag_i(sf), .serial_en_i(se), .twowire_flag_i(twf),
        .twowire_en_i(twe), .int_take_o(take), .vector_o(vec),
        .set_mask_o(smask), .cpu_clk_run_o(clkrun), .osc_run_o(oscrun),
        .timer_clear_o(tclr), .int_reset_o(irst), .mode_sample_o(msamp));
    irc_cpu_model cpu (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .set_mask_i(smask), .mask_wr_i(mwr), .mask_val_i(mval),
        .step_i(step), .mask_o(mask), .instr_done_o(idone));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (msamp === 1'b1) ms_cnt++;
        if (poe === 1'b1) oe_cnt++;
        if (osc_on) osc <= ~osc;
    end
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clock_i);
        while (ack !== 1'b1) @(posedge clock_i);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic run_instr();
        tk = 1'b0;
        step <= 1'b1;
        @(posedge clock_i);
        step <= 1'b0;
        repeat (4) begin
            @(posedge clock_i);
            if (take === 1'b1) {tk, v} = {1'b1, vec};
        end
    endtask
    task automatic unmask();
        mval <= 1'b0;
        mwr <= 1'b1;
        @(posedge clock_i);
        mwr <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic expect_take(input logic [15:0] e);
        unmask();
        run_instr();
        check({tk, v}, {1'b1, e});
    endtask
    task automatic irq_pulse();
        irq_n <= 1'b0;
        repeat (2) @(posedge clock_i);
        irq_n <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask
    task automatic rst_case(input int src, input int len);
        oe_cnt = 0;
        ms_cnt = 0;
        wdog <= (src == 0);
        illeg <= (src == 1);
        ext_n <= (src != 2);
        repeat (len) @(posedge clock_i);
        {wdog, illeg, ext_n} <= 3'b001;
        repeat (12) @(posedge clock_i);
        while (irst !== 1'b0) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
    endtask
    initial begin
        #3000000;
        err_count++;
        finish_test();
    end
    initial begin
        {cyc, stb, we, osc, osc_on, wdog, illeg, step, mwr, software_trap_instruction, stp} = '0;
        {wt, tof, toe, trf, tre, sf, se, twf, twe} = '0;
        {irq_n, por, ext_n, mval} = '1;
        {reset_n_i, adr, wdat} = '0;
        r = $urandom(32'h2B59843C);
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        por <= 1'b0;
        while (irst !== 1'b0) @(posedge clock_i);
        wb(1'b0, 8'h48, 8'h0);
        check(r, 32'h0);
        wb(1'b0, 8'h00, 8'h0);
        check(r, 32'h0);
        for (int i = 0; i < 12; i++) begin
            {tof, toe, trf, tre, sf, se, twf, twe} <= 8'($urandom);
            mval <= 1'($urandom);
            mwr <= 1'b1;
            @(posedge clock_i);
            mwr <= 1'b0;
            @(posedge clock_i);
            run_instr();
            t = (tof & toe) | (trf & tre);
            check(tk, !mval & (t | (sf & se) | (twf & twe)));
            if (tk) check(v, t ? 16'h1FF8 : (sf & se) ? 16'h1FF4 : 16'h1FF2);
        end
        {tof, toe, trf, tre, sf, se, twf, twe} <= 8'h00;
        mval <= 1'b1;
        mwr <= 1'b1;
        software_trap_instruction <= 1'b1;
        @(posedge clock_i);
        {mwr, software_trap_instruction} <= 2'b00;
        @(posedge clock_i);
        run_instr();
        check({tk, v}, {1'b1, 16'h1FFC});
        {tof, toe} <= 2'b11;
        unmask();
        software_trap_instruction <= 1'b1;
        @(posedge clock_i);
        {software_trap_instruction, sf, se} <= 3'b011;
        @(posedge clock_i);
        expect_take(16'h1FF8);
        tof <= 1'b0;
        expect_take(16'h1FFC);
        expect_take(16'h1FF4);
        {sf, tof} <= 2'b01;
        irq_pulse();
        expect_take(16'h1FFA);
        irq_pulse();
        expect_take(16'h1FFA);
        expect_take(16'h1FF8);
        tof <= 1'b0;
        osc_on <= 1'b1;
        r = '0;
        while (r[7] !== 1'b1) begin
            repeat (64) @(posedge clock_i);
            wb(1'b0, 8'h48, 8'h0);
        end
        osc_on <= 1'b0;
        check(r, 32'h80);
        unmask();
        run_instr();
        check(tk, 1'b0);
        wb(1'b1, 8'h48, 8'hC0);
        wb(1'b0, 8'h48, 8'h0);
        check(r, 32'hC0);
        expect_take(16'h1FF6);
        wb(1'b1, 8'h48, 8'h40);
        wb(1'b0, 8'h48, 8'h0);
        check(r, 32'h40);
        wt <= 1'b1;
        @(posedge clock_i);
        wt <= 1'b0;
        repeat (3) @(posedge clock_i);
        check(clkrun, 1'b0);
        wb(1'b0, 8'h4C, 8'h0);
        check(r, 32'h40);
        {twf, twe} <= 2'b11;
        while (clkrun !== 1'b1) @(posedge clock_i);
        {twf, twe} <= 2'b00;
        stp <= 1'b1;
        @(posedge clock_i);
        stp <= 1'b0;
        repeat (3) @(posedge clock_i);
        check(oscrun, 1'b0);
        irq_pulse();
        while (clkrun !== 1'b1) @(posedge clock_i);
        check(oscrun, 1'b1);
        expect_take(16'h1FFA);
        rst_case(0, 6);
        check(oe_cnt >= 6, 1'b1);
        check(ms_cnt, 1);
        wb(1'b0, 8'h48, 8'h0);
        check(r, 32'h0);
        rst_case(1, 1);
        check(oe_cnt >= 3 && oe_cnt <= 4, 1'b1);
        check(ms_cnt, 0);
        rst_case(2, 6);
        check(oe_cnt >= 3 && oe_cnt <= 4, 1'b1);
        check(ms_cnt, 1);
        finish_test();
    end
endmodule
bind irc_core irc_core_properties #(.STARTUP(STARTUP)) u_props (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .por_i(por_i),
    .mask_bit_i(mask_bit_i), .instr_done_i(instr_done_i),
    .stop_exec_i(stop_exec_i), .wait_exec_i(wait_exec_i),
    .int_take_o(int_take_o), .vector_o(vector_o), .set_mask_o(set_mask_o),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
    .int_reset_o(int_reset_o), .cpu_clk_run_o(cpu_clk_run_o),
    .osc_run_o(osc_run_o), .timer_clear_o(timer_clear_o));
`default_nettype wire
